/* File: logic/ata_idle_cmd.sv */
// Task-file registers, identify-word store and idle command engine.
// Assumes an Avalon-MM master on the same clock; no other clock domain.
//
// Notes on behaviour
// - level bit is 1 at maximum security
// - enhanced erase bit only when implemented
// - expired count aborts unlock and erase
// - freeze, lock, enable bits follow security state
// - capability bit shows security feature set
// - valid bit when described, next bit zero
// - report missing or disabled level one commands
// - low twelve bits hold maximum current mA
// - bit zero shows key scheme, rest zero
// - max PIO field codes 0 to 2
// - max multiword DMA field codes 0 to 2
// - selected PIO field codes 0 to 2
// - selected DMA field, top four bits zero
// - card I/O timing codes 0 to 3
// - memory timing codes 0 to 3, upper zero
// - idle command: busy, idle, release, interrupt
// - nonzero count arms power-down timer, 5 ms per count
// - idle immediate keeps power-down timer setting
// - drive parameters from sector count, head only
//
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
module ata_idle_cmd #(
	parameter int TICK_CYCLES = ata_idle_pkg::AUTO_PD_STEP_CYCLES,
	parameter int ATTEMPTS = ata_idle_pkg::SEC_ATTEMPTS
) (
	input wire logic i_sys_clk,
	input wire logic i_arst_n,
	input wire logic [7:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	output logic o_busy_flag,
	output logic o_host_irq,
	output logic o_idle_mode,
	output logic o_power_down,
	output logic o_sec_cmd_start,
	output logic [7:0] o_sectors_per_track,
	output logic [ata_idle_pkg::HEAD_W-1:0] o_max_head
);
	import ata_idle_pkg::*;

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	logic [7:0] feature_reg;
	logic [7:0] sector_count_reg;
	logic [7:0] sector_number_reg;
	logic [7:0] cylinder_low_reg;
	logic [7:0] cylinder_high_reg;
	logic [7:0] drive_head_reg;
	logic [7:0] command_reg;
	logic [SEC_B_LEVEL:0] sec_cfg;
	logic [15:0] pwr_cfg;
	logic key_cfg;
	logic [IDE_W-1:0] tim_ide;
	logic [CARD_W-1:0] tim_card;
	logic [ATT_W-1:0] attempts;
	logic [7:0] pd_count;
	logic auto_pd_en;
	logic cmd_error;
	logic timer_arm;
	logic timer_stop;
	logic timer_expired;
	cmd_state_t state;

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	function automatic logic code_ok(input logic [FIELD_W-1:0] code,
			input logic [FIELD_W-1:0] max_code);
		code_ok = (code <= max_code);
	endfunction

	function automatic logic is_idle(input logic [7:0] code);
		is_idle = (code == CMD_IDLE_A) || (code == CMD_IDLE_B);
	endfunction

	function automatic logic is_idle_imm(input logic [7:0] code);
		is_idle_imm = (code == CMD_IDLE_IMM_A) || (code == CMD_IDLE_IMM_B);
	endfunction

	wire [5:0] idx = i_avs_address[7:2];
	wire rd_take = i_avs_read && !o_avs_waitrequest;
	wire wr_take = i_avs_write && !o_avs_waitrequest;
	wire wr_byte0 = wr_take && i_avs_byteenable[0];
	// Wider config registers need both low lanes; a partial write is dropped
	wire wr_half = wr_take && (i_avs_byteenable[1:0] == 2'b11);
	wire ready = (state == ST_READY);
	// Task file is frozen while busy so a command sees stable parameters
	wire tf_wr = wr_byte0 && ready;
	wire cmd_take = tf_wr && (idx == IDX_COMMAND);
	wire status_rd = rd_take && (idx == IDX_COMMAND);
	wire sec_fail = wr_take && i_avs_byteenable[2] && (idx == IDX_SEC_CFG)
		&& i_avs_writedata[SEC_B_FAIL];
	wire expired = (attempts == '0);
	wire [7:0] wd8 = i_avs_writedata[7:0];

	// Reserved timing codes are refused field by field
	logic [IDE_W-1:0] next_tim_ide;
	logic [CARD_W-1:0] next_tim_card;
	genvar g;
	generate
		for (g = 0; g < IDE_FIELDS; g++) begin : g_ide
			assign next_tim_ide[g*FIELD_W +: FIELD_W] =
				code_ok(i_avs_writedata[g*FIELD_W +: FIELD_W], IDE_CODE_MAX) ?
				i_avs_writedata[g*FIELD_W +: FIELD_W] :
				tim_ide[g*FIELD_W +: FIELD_W];
		end
		for (g = 0; g < CARD_FIELDS; g++) begin : g_card
			assign next_tim_card[g*FIELD_W +: FIELD_W] =
				code_ok(i_avs_writedata[g*FIELD_W +: FIELD_W], CARD_CODE_MAX) ?
				i_avs_writedata[g*FIELD_W +: FIELD_W] :
				tim_card[g*FIELD_W +: FIELD_W];
		end
	endgenerate

	// ----------------------------------------
	// Identify words and readback
	// ----------------------------------------
	logic [15:0] word_sec;
	logic [15:0] word_pwr;
	logic [15:0] word_key;
	logic [15:0] word_ide;
	logic [15:0] word_card;

	ata_identify_words u_words (
		.i_sec_cfg(sec_cfg),
		.i_expired(expired),
		.i_pwr_cfg(pwr_cfg),
		.i_key_cfg(key_cfg),
		.i_tim_ide(tim_ide),
		.i_tim_card(tim_card),
		.o_word_sec(word_sec),
		.o_word_pwr(word_pwr),
		.o_word_key(word_key),
		.o_word_ide(word_ide),
		.o_word_card(word_card)
	);

	wire [7:0] tf_status = {o_busy_flag, !o_busy_flag, 5'h00, cmd_error};
	logic [15:0] status_word;
	always_comb begin
		status_word = '0;
		status_word[ST_B_BUSY] = o_busy_flag;
		status_word[ST_B_IDLE] = o_idle_mode;
		status_word[ST_B_PD] = o_power_down;
		status_word[ST_B_PD_EN] = auto_pd_en;
		status_word[ST_B_IRQ] = o_host_irq;
		status_word[ST_B_ABORT] = cmd_error;
		status_word[ST_B_EXPIRE] = expired;
		status_word[ST_ATT_LSB +: ATT_W] = attempts;
	end

	wire [15:0] geom_word = 16'({o_max_head, o_sectors_per_track});
	wire [15:0] read_mux =
		(idx == IDX_FEATURE) ? {8'h00, feature_reg} :
		(idx == IDX_SECTOR_COUNT) ? {8'h00, sector_count_reg} :
		(idx == IDX_SECTOR_NUMBER) ? {8'h00, sector_number_reg} :
		(idx == IDX_CYLINDER_LOW) ? {8'h00, cylinder_low_reg} :
		(idx == IDX_CYLINDER_HIGH) ? {8'h00, cylinder_high_reg} :
		(idx == IDX_DRIVE_HEAD) ? {8'h00, drive_head_reg} :
		(idx == IDX_COMMAND) ? {8'h00, tf_status} :
		(idx == IDX_STATUS) ? status_word :
		(idx == IDX_SEC_CFG) ? 16'(sec_cfg) :
		(idx == IDX_PWR_CFG) ? pwr_cfg :
		(idx == IDX_KEY_CFG) ? 16'(key_cfg) :
		(idx == IDX_TIM_IDE) ? 16'(tim_ide) :
		(idx == IDX_TIM_CARD) ? 16'(tim_card) :
		(idx == IDX_ID_SEC) ? word_sec :
		(idx == IDX_ID_PWR) ? word_pwr :
		(idx == IDX_ID_KEY) ? word_key :
		(idx == IDX_ID_IDE) ? word_ide :
		(idx == IDX_ID_CARD) ? word_card :
		(idx == IDX_GEOM) ? geom_word :
		16'h0000;

	// ----------------------------------------
	// Avalon slave: one wait cycle per access
	// ----------------------------------------
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_avs_waitrequest <= 1'b1;
			o_avs_readdata <= 32'h0000_0000;
		end else begin
			o_avs_waitrequest <= !((i_avs_read || i_avs_write) && o_avs_waitrequest);
			if (i_avs_read && o_avs_waitrequest) begin
				o_avs_readdata <= {16'h0000, read_mux};
			end
		end
	end

	// ----------------------------------------
	// Task file
	// ----------------------------------------
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			feature_reg <= 8'h00;
			sector_count_reg <= 8'h00;
			sector_number_reg <= 8'h00;
			cylinder_low_reg <= 8'h00;
			cylinder_high_reg <= 8'h00;
			drive_head_reg <= 8'h00;
			command_reg <= 8'h00;
		end else if (tf_wr) begin
			if (idx == IDX_FEATURE) feature_reg <= wd8;
			if (idx == IDX_SECTOR_COUNT) sector_count_reg <= wd8;
			if (idx == IDX_SECTOR_NUMBER) sector_number_reg <= wd8;
			if (idx == IDX_CYLINDER_LOW) cylinder_low_reg <= wd8;
			if (idx == IDX_CYLINDER_HIGH) cylinder_high_reg <= wd8;
			if (idx == IDX_DRIVE_HEAD) drive_head_reg <= wd8;
			if (idx == IDX_COMMAND) command_reg <= wd8;
		end
	end

	// ----------------------------------------
	// Identify configuration
	// ----------------------------------------
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			sec_cfg <= '0;
			pwr_cfg <= 16'h0000;
			key_cfg <= 1'b0;
			tim_ide <= '0;
			tim_card <= '0;
		end else if (wr_half) begin
			if (idx == IDX_SEC_CFG) sec_cfg <= i_avs_writedata[SEC_B_LEVEL:0];
			if (idx == IDX_PWR_CFG) pwr_cfg <= i_avs_writedata[15:0];
			if (idx == IDX_KEY_CFG) key_cfg <= i_avs_writedata[KEY_B_CONTENT];
			if (idx == IDX_TIM_IDE) tim_ide <= next_tim_ide;
			if (idx == IDX_TIM_CARD) tim_card <= next_tim_card;
		end
	end

	// Only a power-on or hard reset refills the attempt count
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			attempts <= ATT_W'(ATTEMPTS);
		end else if (sec_fail && !expired) begin
			attempts <= attempts - ATT_W'(1);
		end
	end

	// ----------------------------------------
	// Command sequencer
	// ----------------------------------------
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state <= ST_READY;
			o_busy_flag <= 1'b0;
		end else begin
			unique case (state)
				ST_READY: begin
					if (cmd_take) begin
						state <= ST_EXEC;
						o_busy_flag <= 1'b1;
					end
				end
				ST_EXEC: begin
					state <= ST_FINISH;
				end
				ST_FINISH: begin
					state <= ST_READY;
					o_busy_flag <= 1'b0;
				end
			endcase
		end
	end

	// Completion sets the interrupt; a status read in that cycle loses
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_host_irq <= 1'b0;
		end else if (state == ST_FINISH) begin
			o_host_irq <= 1'b1;
		end else if (status_rd || cmd_take) begin
			o_host_irq <= 1'b0;
		end
	end

	wire exec = (state == ST_EXEC);
	wire run_idle = exec && is_idle(command_reg);
	wire run_imm = exec && is_idle_imm(command_reg);
	wire run_init = exec && (command_reg == CMD_INIT_PARAMS);
	wire run_sec = exec && ((command_reg == CMD_SEC_UNLOCK)
		|| (command_reg == CMD_SEC_ERASE));

	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cmd_error <= 1'b0;
			o_sec_cmd_start <= 1'b0;
		end else begin
			o_sec_cmd_start <= run_sec && !expired;
			if (cmd_take) begin
				cmd_error <= 1'b0;
			end else if (exec) begin
				// Unhandled codes and expired security commands abort
				cmd_error <= (run_sec && expired)
					|| !(run_idle || run_imm || run_init || run_sec);
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_sectors_per_track <= 8'h00;
			o_max_head <= '0;
		end else if (run_init) begin
			o_sectors_per_track <= sector_count_reg;
			o_max_head <= drive_head_reg[HEAD_W-1:0];
		end
	end

	// ----------------------------------------
	// Idle and automatic power-down
	// ----------------------------------------
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			auto_pd_en <= 1'b0;
			pd_count <= 8'h00;
		end else if (run_idle) begin
			auto_pd_en <= (sector_count_reg != 8'h00);
			if (sector_count_reg != 8'h00) begin
				pd_count <= sector_count_reg;
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_idle_mode <= 1'b0;
			o_power_down <= 1'b0;
		end else if (cmd_take) begin
			o_power_down <= 1'b0;
		end else if (exec) begin
			o_idle_mode <= run_idle || run_imm;
		end else if (timer_expired && ready) begin
			o_idle_mode <= 1'b0;
			o_power_down <= 1'b1;
		end
	end

	// Idle immediate leaves the timer setting alone but still restarts it
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			timer_arm <= 1'b0;
			timer_stop <= 1'b0;
		end else begin
			timer_arm <= (state == ST_FINISH) && auto_pd_en;
			timer_stop <= cmd_take || (run_idle && sector_count_reg == 8'h00);
		end
	end

	auto_pd_timer #(
		.TICK_CYCLES(TICK_CYCLES),
		.COUNT_W(8)
	) u_timer (
		.i_sys_clk(i_sys_clk),
		.i_arst_n(i_arst_n),
		.i_arm(timer_arm),
		.i_stop(timer_stop),
		.i_count(pd_count),
		.o_expired(timer_expired)
	);
endmodule // ata_idle_cmd

/* File: logic/ata_idle_pkg.sv */
// Constants shared by the identify-word and idle command logic.
// Assumes a single 25 MHz clock domain and an Avalon-MM register port.
package ata_idle_pkg;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_HZ = 25_000_000;
	localparam int AUTO_PD_STEP_MS = 5;
	localparam int AUTO_PD_STEP_CYCLES = (CLK_HZ / 1000) * AUTO_PD_STEP_MS;
	localparam int SEC_ATTEMPTS = 5;
	localparam int ATT_W = 4;
	localparam int HEAD_W = 4;
	localparam int FIELD_W = 3;

	// ----------------------------------------
	// Register indices (byte address = 4 * index)
	// ----------------------------------------
	localparam logic [5:0] IDX_FEATURE = 6'h01;
	localparam logic [5:0] IDX_SECTOR_COUNT = 6'h02;
	localparam logic [5:0] IDX_SECTOR_NUMBER = 6'h03;
	localparam logic [5:0] IDX_CYLINDER_LOW = 6'h04;
	localparam logic [5:0] IDX_CYLINDER_HIGH = 6'h05;
	localparam logic [5:0] IDX_DRIVE_HEAD = 6'h06;
	localparam logic [5:0] IDX_COMMAND = 6'h07;
	localparam logic [5:0] IDX_STATUS = 6'h08;
	localparam logic [5:0] IDX_SEC_CFG = 6'h09;
	localparam logic [5:0] IDX_PWR_CFG = 6'h0A;
	localparam logic [5:0] IDX_KEY_CFG = 6'h0B;
	localparam logic [5:0] IDX_TIM_IDE = 6'h0C;
	localparam logic [5:0] IDX_TIM_CARD = 6'h0D;
	localparam logic [5:0] IDX_ID_SEC = 6'h0E;
	localparam logic [5:0] IDX_ID_PWR = 6'h0F;
	localparam logic [5:0] IDX_ID_KEY = 6'h10;
	localparam logic [5:0] IDX_ID_IDE = 6'h11;
	localparam logic [5:0] IDX_ID_CARD = 6'h12;
	localparam logic [5:0] IDX_GEOM = 6'h13;

	// ----------------------------------------
	// Command codes
	// ----------------------------------------
	localparam logic [7:0] CMD_IDLE_A = 8'h97;
	localparam logic [7:0] CMD_IDLE_B = 8'hE3;
	localparam logic [7:0] CMD_IDLE_IMM_A = 8'h95;
	localparam logic [7:0] CMD_IDLE_IMM_B = 8'hE1;
	localparam logic [7:0] CMD_INIT_PARAMS = 8'h91;
	localparam logic [7:0] CMD_SEC_UNLOCK = 8'hF2;
	localparam logic [7:0] CMD_SEC_ERASE = 8'hF4;

	// ----------------------------------------
	// Identify word fields
	// ----------------------------------------
	localparam int SEC_B_LEVEL = 8;
	localparam int SEC_B_ENH = 5;
	localparam int SEC_B_EXPIRE = 4;
	localparam int SEC_B_FREEZE = 3;
	localparam int SEC_B_LOCK = 2;
	localparam int SEC_B_ENABLE = 1;
	localparam int SEC_B_CAP = 0;
	localparam int SEC_B_FAIL = 16;
	localparam int PWR_B_VALID = 15;
	localparam int PWR_B_RSV = 14;
	localparam int PWR_B_NO_L1 = 13;
	localparam int PWR_B_L1_DIS = 12;
	localparam int PWR_CUR_W = 12;
	localparam int KEY_B_CONTENT = 0;
	localparam int IDE_FIELDS = 4;
	localparam int CARD_FIELDS = 2;
	localparam int IDE_W = IDE_FIELDS * FIELD_W;
	localparam int CARD_W = CARD_FIELDS * FIELD_W;
	localparam logic [FIELD_W-1:0] IDE_CODE_MAX = 3'h2;
	localparam logic [FIELD_W-1:0] CARD_CODE_MAX = 3'h3;
	localparam int GEOM_HEAD_LSB = 8;

	// ----------------------------------------
	// Status bits
	// ----------------------------------------
	localparam int ST_B_BUSY = 0;
	localparam int ST_B_IDLE = 1;
	localparam int ST_B_PD = 2;
	localparam int ST_B_PD_EN = 3;
	localparam int ST_B_IRQ = 4;
	localparam int ST_B_ABORT = 5;
	localparam int ST_B_EXPIRE = 6;
	localparam int ST_ATT_LSB = 8;
	localparam int TF_B_BSY = 7;
	localparam int TF_B_RDY = 6;
	localparam int TF_B_ERR = 0;

	typedef enum logic [2:0] {
		ST_READY = 3'b001,
		ST_EXEC = 3'b010,
		ST_FINISH = 3'b100
	} cmd_state_t;
endpackage

/* File: logic/auto_pd_timer.sv */
// Automatic power-down timer: counts down in fixed steps after arming.
// Assumes arm and stop are single-cycle pulses from the same clock.
`timescale 1ns/1ps
module auto_pd_timer #(
	parameter int TICK_CYCLES = ata_idle_pkg::AUTO_PD_STEP_CYCLES,
	parameter int COUNT_W = 8
) (
	input wire logic i_sys_clk,
	input wire logic i_arst_n,
	input wire logic i_arm,
	input wire logic i_stop,
	input wire logic [COUNT_W-1:0] i_count,
	output logic o_expired
);
	import ata_idle_pkg::*;
	localparam int PRE_W = $clog2(TICK_CYCLES + 1);
	localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYCLES - 1);
	localparam logic [COUNT_W-1:0] LAST_STEP = COUNT_W'(1);

	logic [PRE_W-1:0] prescale;
	logic [COUNT_W-1:0] remaining;
	logic running;
	wire tick = running && (prescale == PRE_LAST);

	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			prescale <= '0;
			remaining <= '0;
			running <= 1'b0;
			o_expired <= 1'b0;
		end else begin
			o_expired <= 1'b0;
			if (i_stop) begin
				running <= 1'b0;
			end else if (i_arm && i_count != '0) begin
				running <= 1'b1;
				prescale <= '0;
				remaining <= i_count;
			end else if (tick) begin
				prescale <= '0;
				remaining <= remaining - LAST_STEP;
				running <= (remaining != LAST_STEP);
				o_expired <= (remaining == LAST_STEP);
			end else if (running) begin
				prescale <= prescale + PRE_W'(1);
			end
		end
	end
endmodule // auto_pd_timer

/* File: logic/ata_identify_words.sv */
// Assembles the security, power, key and advanced timing identify words.
// Assumes its inputs are stable configuration flops; purely combinational.
`timescale 1ns/1ps
module ata_identify_words (
	input wire logic [ata_idle_pkg::SEC_B_LEVEL:0] i_sec_cfg,
	input wire logic i_expired,
	input wire logic [15:0] i_pwr_cfg,
	input wire logic i_key_cfg,
	input wire logic [ata_idle_pkg::IDE_W-1:0] i_tim_ide,
	input wire logic [ata_idle_pkg::CARD_W-1:0] i_tim_card,
	output logic [15:0] o_word_sec,
	output logic [15:0] o_word_pwr,
	output logic [15:0] o_word_key,
	output logic [15:0] o_word_ide,
	output logic [15:0] o_word_card
);
	import ata_idle_pkg::*;
	// Without the feature set every state bit reads zero
	wire cap = i_sec_cfg[SEC_B_CAP];
	wire enabled = cap && i_sec_cfg[SEC_B_ENABLE];

	always_comb begin
		o_word_sec = '0;
		o_word_sec[SEC_B_LEVEL] = enabled && i_sec_cfg[SEC_B_LEVEL];
		o_word_sec[SEC_B_ENH] = cap && i_sec_cfg[SEC_B_ENH];
		o_word_sec[SEC_B_EXPIRE] = cap && i_expired;
		o_word_sec[SEC_B_FREEZE] = cap && i_sec_cfg[SEC_B_FREEZE];
		o_word_sec[SEC_B_LOCK] = cap && i_sec_cfg[SEC_B_LOCK];
		o_word_sec[SEC_B_ENABLE] = enabled;
		o_word_sec[SEC_B_CAP] = cap;
	end

	always_comb begin
		o_word_pwr = '0;
		o_word_pwr[PWR_B_VALID] = i_pwr_cfg[PWR_B_VALID];
		o_word_pwr[PWR_B_RSV] = 1'b0;
		o_word_pwr[PWR_B_NO_L1] = i_pwr_cfg[PWR_B_NO_L1];
		o_word_pwr[PWR_B_L1_DIS] = i_pwr_cfg[PWR_B_L1_DIS];
		o_word_pwr[PWR_CUR_W-1:0] = i_pwr_cfg[PWR_CUR_W-1:0];
	end

	assign o_word_key = {15'h0000, i_key_cfg};
	assign o_word_ide = {4'h0, i_tim_ide};
	assign o_word_card = {10'h000, i_tim_card};
endmodule // ata_identify_words

/* File: testbench/ata_idle_cmd_assertions.sv */
// Port checker for the idle command block.
// Assumes it is bound to the block; a single clock domain.
`timescale 1ns/1ps
module ata_idle_cmd_assertions (
	input wire logic i_sys_clk,
	input wire logic i_arst_n,
	input wire logic [7:0] i_avs_address,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	input wire logic o_avs_waitrequest,
	input wire logic o_busy_flag,
	input wire logic o_host_irq,
	input wire logic o_idle_mode,
	input wire logic o_power_down,
	input wire logic o_sec_cmd_start,
	input wire logic [7:0] o_sectors_per_track
);
	import ata_idle_pkg::*;
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_arst_n);
	// ----------------------------------------
	// Command acceptance
	// ----------------------------------------
	wire cmd_hit = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0]
		&& i_avs_address[7:2] == IDX_COMMAND;
	wire cmd_go = cmd_hit && !o_busy_flag;
	wire [7:0] code = i_avs_writedata[7:0];
	wire idle_go = cmd_go && (code inside {CMD_IDLE_A, CMD_IDLE_B, CMD_IDLE_IMM_A, CMD_IDLE_IMM_B});
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	a_busy_on_cmd: assert property (cmd_go |=> o_busy_flag)
		else $error("busy did not follow a command");
	a_busy_cause: assert property ($rose(o_busy_flag) |-> $past(cmd_go))
		else $error("busy rose without a command");
	a_busy_two: assert property ($rose(o_busy_flag) |-> o_busy_flag[*2] ##1 !o_busy_flag)
		else $error("busy did not last two cycles");
	a_irq_done: assert property ($fell(o_busy_flag) |-> o_host_irq)
		else $error("no interrupt at completion");
	a_idle_set: assert property (idle_go |-> ##3 (o_idle_mode && !o_busy_flag))
		else $error("idle mode not entered");
	a_sec_pulse: assert property (o_sec_cmd_start |=> !o_sec_cmd_start)
		else $error("security start longer than one cycle");
	a_pd_ready: assert property ($rose(o_power_down) |-> !o_busy_flag)
		else $error("power down during a command");
	a_pd_no_idle: assert property ($rose(o_power_down) |-> ##[0:1] !o_idle_mode)
		else $error("idle mode kept in power down");
	a_geom_hold: assert property ($changed(o_sectors_per_track) |-> o_busy_flag || $past(o_busy_flag))
		else $error("geometry changed outside a command");
endmodule // ata_idle_cmd_assertions

/* File: testbench/ata_host_model.sv */
// Host side model: an Avalon-MM master for the task-file registers.
// Assumes the slave answers with waitrequest low; bounded wait.
`timescale 1ns/1ps
module ata_host_model (
	input wire logic i_sys_clk,
	input wire logic i_wait,
	input wire logic [31:0] i_rdata,
	output logic [7:0] o_addr,
	output logic o_rd,
	output logic o_wr,
	output logic [31:0] o_wdata,
	output logic [3:0] o_be
);
	initial begin
		o_addr = 8'h00;
		o_rd = 1'b0;
		o_wr = 1'b0;
		o_wdata = 32'h0000_0000;
		o_be = 4'h0;
	end
	task automatic xfer(input logic w, input logic [5:0] idx, input logic [31:0] d,
		input logic [3:0] be, output logic [31:0] q, output bit to);
		int n;
		to = 1'b1;
		q = 32'h0000_0000;
		@(posedge i_sys_clk);
		o_wr <= w;
		o_rd <= !w;
		o_addr <= {idx, 2'b00};
		o_wdata <= d;
		o_be <= be;
		for (n = 0; n < 16; n++) begin
			@(posedge i_sys_clk);
			if (i_wait === 1'b0) begin
				q = i_rdata;
				to = 1'b0;
				break;
			end
		end
		o_wr <= 1'b0;
		o_rd <= 1'b0;
		// Released address and data lines never keep the last value
		o_addr <= ~o_addr;
		o_wdata <= ~o_wdata;
	endtask
endmodule // ata_host_model

/* File: testbench/ata_idle_cmd_bench.sv */
// Self-checking bench for the idle command block.
// Assumes the host model drives the register bus; short timer counts.
`timescale 1ns/1ps
module ata_idle_cmd_bench;
	import ata_idle_pkg::*;
	localparam int TICK = 4;
	localparam int ATT = 2;
	logic clk, arst_n, rd, wr, wait_req, busy, irq, idle, pd, sec;
	logic [7:0] addr, spt;
	logic [31:0] wdata, rdata;
	logic [3:0] be, head;
	int n_errors = 0;
	int compares = 0;
	int n_sec = 0;
	int cyc = 0;
	wire [31:0] att_bits = 32'(ATT) << ST_ATT_LSB;
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (sec === 1'b1) n_sec <= n_sec + 1;
	end
	ata_idle_cmd #(.TICK_CYCLES(TICK), .ATTEMPTS(ATT)) i_dut (.i_sys_clk(clk), .i_arst_n(arst_n),
		.i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
		.i_avs_byteenable(be), .o_avs_readdata(rdata), .o_avs_waitrequest(wait_req),
		.o_busy_flag(busy), .o_host_irq(irq), .o_idle_mode(idle), .o_power_down(pd),
		.o_sec_cmd_start(sec), .o_sectors_per_track(spt), .o_max_head(head));
	ata_host_model i_host (.i_sys_clk(clk), .i_wait(wait_req), .i_rdata(rdata), .o_addr(addr),
		.o_rd(rd), .o_wr(wr), .o_wdata(wdata), .o_be(be));
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic acc(input logic w, input logic [5:0] idx, input logic [31:0] d,
		input logic [3:0] b, output logic [31:0] q);
		bit to;
		i_host.xfer(w, idx, d, b, q, to);
		if (to) begin
			n_errors++;
			$display("mismatch waitrequest expected 0 seen 1");
			tally_and_finish();
		end
	endtask
	task automatic wr_reg(input logic [5:0] idx, input logic [31:0] d, input logic [3:0] b = 4'hF);
		logic [31:0] q;
		acc(1'b1, idx, d, b, q);
	endtask
	task automatic rdc(input logic [5:0] idx, input logic [31:0] e);
		logic [31:0] q;
		acc(1'b0, idx, 32'h0000_0000, 4'hF, q);
		chk($sformatf("reg %0d", idx), e, q);
	endtask
	// Busy lasts a fixed two cycles
	task automatic cmd(input logic [7:0] code);
		wr_reg(IDX_COMMAND, {24'h000000, code});
		repeat (3) @(posedge clk);
		@(negedge clk);
		chk("busy", 32'h0, busy);
		chk("irq", 32'h1, irq);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		chk("outputs", 32'h0, {busy, irq, idle, pd, sec, spt, head});
		rdc(IDX_STATUS, att_bits);
		wr_reg(6'h3F, 32'hFFFF_FFFF);
		rdc(6'h3F, 32'h0000_0000);
		$display("test reset done");
	endtask
	task automatic t_ident();
		wr_reg(IDX_SEC_CFG, 32'h0000_012F);
		rdc(IDX_ID_SEC, 32'h0000_012F);
		wr_reg(IDX_SEC_CFG, 32'h0000_010D);
		rdc(IDX_ID_SEC, 32'h0000_000D);
		wr_reg(IDX_SEC_CFG, 32'h0000_012E);
		rdc(IDX_ID_SEC, 32'h0000_0000);
		wr_reg(IDX_SEC_CFG, 32'h0000_0001, 4'h1);
		rdc(IDX_ID_SEC, 32'h0000_0000);
		wr_reg(IDX_PWR_CFG, 32'h0000_F123);
		rdc(IDX_ID_PWR, 32'h0000_B123);
		wr_reg(IDX_KEY_CFG, 32'h0000_FFFF);
		rdc(IDX_ID_KEY, 32'h0000_0001);
		$display("test identify done");
	endtask
	task automatic t_timing();
		for (int c = 0; c < 4; c++) begin
			wr_reg(IDX_TIM_IDE, 32'hF000 | 32'(c * 12'h249));
			rdc(IDX_ID_IDE, 32'((c < 3 ? c : 2) * 12'h249));
		end
		for (int c = 0; c < 5; c++) begin
			wr_reg(IDX_TIM_CARD, 32'hFFC0 | 32'(c * 9));
			rdc(IDX_ID_CARD, 32'((c < 4 ? c : 3) * 9));
		end
		$display("test timing done");
	endtask
	task automatic t_idle();
		int t0;
		wr_reg(IDX_SECTOR_COUNT, 32'h0000_0003);
		cmd(CMD_IDLE_A);
		t0 = cyc;
		rdc(IDX_STATUS, att_bits | 32'h1A);
		rdc(IDX_COMMAND, 32'h0000_0040);
		@(negedge clk);
		chk("irq", 32'h0, irq);
		for (int n = 0; n < 100 && pd !== 1'b1; n++) @(negedge clk);
		if (pd !== 1'b1) begin
			chk("pd timeout", 32'h1, pd);
			tally_and_finish();
		end
		chk("pd delay", 32'h1, (cyc - t0 >= 3 * TICK) && (cyc - t0 <= 3 * TICK + 5));
		chk("idle", 32'h0, idle);
		rdc(IDX_STATUS, att_bits | 32'h0C);
		$display("test idle done");
	endtask
	task automatic t_imm();
		wr_reg(IDX_SECTOR_COUNT, 32'h0000_0000);
		cmd(CMD_IDLE_IMM_A);
		chk("pd idle", 32'h1, {pd, idle});
		rdc(IDX_STATUS, att_bits | 32'h1A);
		cmd(CMD_IDLE_B);
		rdc(IDX_STATUS, att_bits | 32'h12);
		cmd(CMD_IDLE_IMM_B);
		rdc(IDX_STATUS, att_bits | 32'h12);
		$display("test immediate done");
	endtask
	task automatic t_params();
		wr_reg(IDX_SECTOR_COUNT, 32'h0000_003F);
		wr_reg(IDX_DRIVE_HEAD, 32'h0000_00A5);
		wr_reg(IDX_CYLINDER_LOW, 32'h0000_0077);
		cmd(CMD_INIT_PARAMS);
		chk("geometry", 32'h0000_053F, {idle, 3'h0, head, spt});
		rdc(IDX_GEOM, 32'h0000_053F);
		$display("test parameters done");
	endtask
	task automatic t_expire();
		cmd(CMD_SEC_UNLOCK);
		chk("sec starts", 32'h1, n_sec);
		wr_reg(IDX_SEC_CFG, 32'h0000_0001);
		repeat (ATT) wr_reg(IDX_SEC_CFG, 32'h0001_0000, 4'h4);
		rdc(IDX_ID_SEC, 32'h0000_0011);
		rdc(IDX_STATUS, 32'h0000_0050);
		cmd(CMD_SEC_ERASE);
		cmd(CMD_SEC_UNLOCK);
		chk("sec starts", 32'h1, n_sec);
		rdc(IDX_COMMAND, 32'h0000_0041);
		// Hard reset is the only way to refill the attempt count
		arst_n <= 1'b0;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		@(negedge clk);
		rdc(IDX_STATUS, att_bits);
		$display("test expire done");
	endtask
	initial begin
		arst_n = 1'b0;
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		@(negedge clk);
		t_reset();
		t_ident();
		t_timing();
		t_idle();
		t_imm();
		t_params();
		t_expire();
		tally_and_finish();
	end
endmodule // ata_idle_cmd_bench
bind ata_idle_cmd ata_idle_cmd_assertions i_chk (.*);
